// >>> hw/flash_pin_front.v
// serial pin front end of a small serial flash: framing, shifting, pause, write protect
// assumes pins arrive unsynchronised; core behind it consumes bytes and supplies read data
//
// Contract
// - deselect: standby, output high impedance
// - ignore serial input while deselected
// - frame only on select edges
// - stay active until timed cycle ends
// - sample input on rising clock
// - change output on falling clock
// - one input line carries everything
// - pause ignores clock, input; output released
// - pause starts only selected, clock low
// - pause keeps interface state
// - pause never disturbs timed cycle
// - write protect gates protection changes
// - pause, protect default inactive (pulled up)
// - modes 0 and 3 only
// - opcode first, bytes msb first
// - bad opcode ignored until reselect
// - short frame does nothing
`timescale 1ns/1ps
`default_nettype none
`include "flash_pins_map.vh"
module flash_pin_front #(
  parameter FIFO_DEPTH = `FIFO_DEPTH_DEF,
  parameter FIFO_AW    = 3
) (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       cs_n_pin,
  input  wire       sck_pin,
  input  wire       si_pin,
  input  wire       pause_n_pin,
  input  wire       wp_n_pin,
  output reg        so_out,
  output reg        so_oe,
  input  wire [7:0] tx_byte,
  output reg        tx_take,
  output wire [7:0] rx_byte,
  output wire       rx_valid,
  input  wire       rx_ready,
  output reg        rx_first,
  output reg        op_start,
  output reg  [7:0] op_code,
  output reg        op_end,
  output reg        op_abort,
  input  wire       core_busy,
  output reg        active,
  output reg        prot_locked,
  output reg        rx_overrun
);

  ////////////////////////////////////////////////////////////////
  // pin synchronisers; pause and protect default high via pull-up, so 1 is inactive
  // sck needs two or more clk_sys cycles per half period, or its edges are missed
  reg [1:0] cs_s_r;
  reg [1:0] sck_s_r;
  reg [1:0] si_s_r;
  reg [1:0] hold_s_r;
  reg [1:0] wp_s_r;
  reg       sck_d_r;
  reg       cs_d_r;

  always @(posedge clk_sys) begin
    if (rst) begin
      cs_s_r   <= 2'h3;
      sck_s_r  <= 2'h0;
      si_s_r   <= 2'h0;
      hold_s_r <= 2'h3;
      wp_s_r   <= 2'h3;
      sck_d_r  <= 1'b0;
      cs_d_r   <= 1'b1;
    end else begin
      cs_s_r   <= {cs_s_r[0], cs_n_pin};
      sck_s_r  <= {sck_s_r[0], sck_pin};
      si_s_r   <= {si_s_r[0], si_pin};
      hold_s_r <= {hold_s_r[0], pause_n_pin};
      wp_s_r   <= {wp_s_r[0], wp_n_pin};
      sck_d_r  <= sck_s_r[1];
      cs_d_r   <= cs_s_r[1];
    end
  end

  wire cs_n     = cs_s_r[1];
  wire sck      = sck_s_r[1];
  wire si       = si_s_r[1];
  wire selected = ~cs_n;
  wire cs_fall  = cs_d_r & ~cs_n;
  wire cs_rise  = ~cs_d_r & cs_n;
  wire sck_rise = ~sck_d_r & sck;
  wire sck_fall = sck_d_r & ~sck;

  ////////////////////////////////////////////////////////////////
  // pause: only enters while selected with clock low, leaves when pin goes high
  reg paused_r;

  always @(posedge clk_sys) begin
    if (rst) begin
      paused_r <= 1'b0;
    end else if (!selected || hold_s_r[1]) begin
      paused_r <= 1'b0;
    end else if (!sck) begin
      paused_r <= 1'b1;
    end
  end

  // edges are masked, not counters cleared, so the bit position survives a pause
  wire shift_in  = selected & ~paused_r & sck_rise;
  wire shift_out = selected & ~paused_r & sck_fall;

  ////////////////////////////////////////////////////////////////
  // receive shifter and frame state
  localparam ST_IDLE = 2'h0;
  localparam ST_OPC  = 2'h1;
  localparam ST_BODY = 2'h2;
  localparam ST_DEAF = 2'h3;

  reg [1:0]  state_r;
  reg [1:0]  state_nxt;
  reg [7:0]  sh_r;
  reg [2:0]  bit_r;
  reg [1:0]  addr_cnt_r;
  reg        need_addr_r;
  reg        fifo_wr_r;
  reg [7:0]  fifo_wd_r;
  reg        first_pend_r;
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire       fifo_out_ready;
  wire [7:0] fifo_out_data;
  wire [7:0] sh_full = {sh_r[6:0], si};

  function opc_known;
    input [7:0] c;
    begin
      case (c)
        `OPC_READ, `OPC_FREAD, `OPC_ERASE4, `OPC_ERASE32A, `OPC_ERASE32B,
        `OPC_CERASE_A, `OPC_CERASE_B, `OPC_CERASE_C, `OPC_PROG, `OPC_WREN,
        `OPC_WRDI, `OPC_RDSR, `OPC_WRSR: opc_known = 1'b1;
        default: opc_known = 1'b0;
      endcase
    end
  endfunction

  function opc_addr;
    input [7:0] c;
    begin
      case (c)
        `OPC_READ, `OPC_FREAD, `OPC_ERASE4, `OPC_ERASE32A, `OPC_ERASE32B,
        `OPC_PROG: opc_addr = 1'b1;
        default:   opc_addr = 1'b0;
      endcase
    end
  endfunction

  wire byte_done = shift_in & (bit_r == `BIT_LAST);

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (cs_fall) begin
          state_nxt = ST_OPC;
        end
      end
      ST_OPC: begin
        if (cs_rise) begin
          state_nxt = ST_IDLE;
        end else if (byte_done) begin
          state_nxt = opc_known(sh_full) ? ST_BODY : ST_DEAF;
        end
      end
      ST_BODY: begin
        if (cs_rise) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_DEAF: begin
        if (cs_rise) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      state_r      <= ST_IDLE;
      sh_r         <= 8'h00;
      bit_r        <= 3'h0;
      addr_cnt_r   <= 2'h0;
      need_addr_r  <= 1'b0;
      fifo_wr_r    <= 1'b0;
      fifo_wd_r    <= 8'h00;
      first_pend_r <= 1'b0;
      op_start     <= 1'b0;
      op_code      <= 8'h00;
      op_end       <= 1'b0;
      op_abort     <= 1'b0;
      rx_overrun   <= 1'b0;
      rx_first     <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      op_start  <= 1'b0;
      op_end    <= 1'b0;
      op_abort  <= 1'b0;
      if (fifo_wr_r && fifo_in_ready) begin
        fifo_wr_r <= 1'b0;
      end
      if (cs_fall) begin
        bit_r      <= 3'h0;
        addr_cnt_r <= 2'h0;
        rx_overrun <= 1'b0;
      end else if (shift_in && state_r != ST_DEAF && state_r != ST_IDLE) begin
        sh_r  <= sh_full;
        bit_r <= bit_r + 3'h1;
        if (byte_done && state_r == ST_OPC) begin
          op_code      <= sh_full;
          need_addr_r  <= opc_addr(sh_full);
          first_pend_r <= 1'b1;
          op_start     <= opc_known(sh_full) & ~opc_addr(sh_full);
        end
        if (byte_done && state_r == ST_BODY) begin
          if (fifo_wr_r && !fifo_in_ready) begin
            rx_overrun <= 1'b1; // core too slow; byte dropped
          end else begin
            fifo_wr_r    <= 1'b1;
            fifo_wd_r    <= sh_full;
            rx_first     <= first_pend_r;
            first_pend_r <= 1'b0;
          end
          if (need_addr_r && addr_cnt_r != `ADDR_BYTES) begin
            addr_cnt_r <= addr_cnt_r + 2'h1;
            op_start   <= (addr_cnt_r == `ADDR_BYTES - 2'h1);
          end
        end
      end
      if (cs_rise && state_r != ST_IDLE) begin
        if (state_r == ST_BODY && (!need_addr_r || addr_cnt_r == `ADDR_BYTES)) begin
          op_end <= 1'b1;
        end else begin
          op_abort <= 1'b1;
        end
      end
    end
  end

  rx_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_rx_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   (fifo_wd_r),
    .in_valid  (fifo_wr_r),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
  );

  ////////////////////////////////////////////////////////////////
  // output stage: keeps rx_byte and rx_valid flop-driven, at one cycle of latency
  // bytes held before a drop: fifo depth, this stage and the one pending write
  reg       rx_valid_r;
  reg [7:0] rx_byte_r;

  // refill whenever the stage is empty or being popped, so a steady reader loses no cycle
  assign fifo_out_ready = ~rx_valid_r | rx_ready;
  assign rx_valid       = rx_valid_r;
  assign rx_byte        = rx_byte_r;

  always @(posedge clk_sys) begin
    if (rst) begin
      rx_valid_r <= 1'b0;
      rx_byte_r  <= 8'h00;
    end else if (fifo_out_ready) begin
      rx_valid_r <= fifo_out_valid;
      rx_byte_r  <= fifo_out_data;
    end
  end

  ////////////////////////////////////////////////////////////////
  // transmit shifter: loads on first falling edge of each byte
  reg [7:0] tx_sh_r;
  reg [2:0] tx_bit_r;

  always @(posedge clk_sys) begin
    if (rst) begin
      tx_sh_r  <= 8'h00;
      tx_bit_r <= 3'h0;
      so_out   <= 1'b0;
      so_oe    <= 1'b0;
      tx_take  <= 1'b0;
    end else begin
      tx_take <= 1'b0;
      if (cs_fall) begin
        tx_bit_r <= 3'h0;
      end else if (shift_out && state_r == ST_BODY) begin
        tx_bit_r <= tx_bit_r + 3'h1;
        if (tx_bit_r == 3'h0) begin
          so_out  <= tx_byte[7];
          tx_sh_r <= {tx_byte[6:0], 1'b0};
          tx_take <= 1'b1;
        end else begin
          so_out  <= tx_sh_r[7];
          tx_sh_r <= {tx_sh_r[6:0], 1'b0};
        end
      end
      // modes 0 and 3 both present their first output bit after a falling edge
      so_oe <= selected & ~paused_r & (state_r == ST_BODY);
    end
  end

  ////////////////////////////////////////////////////////////////
  // standby, and hardware lock
  always @(posedge clk_sys) begin
    if (rst) begin
      active      <= 1'b0;
      prot_locked <= 1'b0;
    end else begin
      // timed cycles run on core_busy alone, which pause never touches
      active      <= selected | core_busy;
      prot_locked <= ~wp_s_r[1];
    end
  end

endmodule // flash_pin_front
`default_nettype wire

// >>> hw/flash_pins_map.vh
// constants for the serial flash pin front end
// assumes inclusion by bare name from design files under hw/
`ifndef FLASH_PINS_MAP_VH
`define FLASH_PINS_MAP_VH
`define BYTE_BITS        4'h8
`define BIT_LAST         3'h7
`define OPC_READ         8'h03
`define OPC_FREAD        8'h0b
`define OPC_ERASE4       8'h20
`define OPC_ERASE32A     8'h52
`define OPC_ERASE32B     8'hd8
`define OPC_CERASE_A     8'h60
`define OPC_CERASE_B     8'hc7
`define OPC_CERASE_C     8'h62
`define OPC_PROG         8'h02
`define OPC_WREN         8'h06
`define OPC_WRDI         8'h04
`define OPC_RDSR         8'h05
`define OPC_WRSR         8'h01
`define ADDR_BYTES       2'h3
`define FIFO_DEPTH_DEF   8
`endif

// >>> hw/rx_fifo.v
// small synchronous fifo for received bytes
// assumes one clock; writer honours in_ready, reader may stall
`timescale 1ns/1ps
`default_nettype none
module rx_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_sys,
  input  wire             rst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            do_wr;
  wire            do_rd;

  assign in_ready  = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data  = mem_r[rd_ptr_r];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  always @(posedge clk_sys) begin
    if (do_wr) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      case ({do_wr, do_rd})
        2'b10:   count_r <= count_r + 1'b1;
        2'b01:   count_r <= count_r - 1'b1;
        default: count_r <= count_r;
      endcase
    end
  end
endmodule // rx_fifo
`default_nettype wire

// >>> bench/flash_pin_monitor.sv
// checker for the serial flash pin front end, bound to its ports
// assumes pins change away from the clk_sys rising edge
`timescale 1ns/1ps
`default_nettype none
module flash_pin_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic pause_n_pin,
  input wire logic wp_n_pin,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic rx_valid,
  input wire logic op_start,
  input wire logic op_end,
  input wire logic op_abort,
  input wire logic core_busy,
  input wire logic active,
  input wire logic prot_locked
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // six edges covers the two-flop sync plus the output register
  sequence idle_s; cs_n_pin [*6]; endsequence
  sequence held_s; (!pause_n_pin && !sck_pin) [*4]; endsequence
  sequence so_move_s; $past(so_oe) && so_oe && $changed(so_out); endsequence
  chk_desel_hiz: assert property (idle_s |-> !so_oe)
    else $error("output driven while deselected");
  chk_pause_hiz: assert property (held_s ##1 !pause_n_pin |-> !so_oe)
    else $error("output driven while paused");
  chk_quiet_rx: assert property ((cs_n_pin && !rx_valid) [*6] |=> !rx_valid)
    else $error("byte received while deselected");
  chk_so_falling: assert property (so_move_s |-> !$past(sck_pin, 2))
    else $error("output moved without a falling clock");
  chk_end_cause: assert property (op_end |-> $past(cs_n_pin, 2) && !op_abort)
    else $error("end pulse without select rise");
  chk_start_sel: assert property (op_start |-> !$past(cs_n_pin, 3))
    else $error("start pulse while deselected");
  chk_go_standby: assert property ((cs_n_pin && !core_busy) [*6] |-> !active)
    else $error("no standby after deselect");
  chk_busy_active: assert property (core_busy [*3] |-> active)
    else $error("standby during timed cycle");
  chk_wp_lock: assert property ((!wp_n_pin) [*5] |-> prot_locked)
    else $error("protect low but not locked");
  chk_wp_free: assert property (wp_n_pin [*5] |-> !prot_locked)
    else $error("protect high but locked");
endmodule // flash_pin_monitor
bind flash_pin_front flash_pin_monitor flash_pin_monitor_i (.*);
`default_nettype wire

// >>> bench/spi_host_model.sv
// host side serial master: framing, msb-first bytes, pause
// assumes clk_sys runs; a half period of sck is 4 clk_sys cycles
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input  wire logic clk_sys,
  input  wire logic so_out,
  input  wire logic so_oe,
  output var  logic cs_n,
  output var  logic sck,
  output var  logic si,
  output var  logic pause_n
);
  logic idle_hi = 1'b0;
  logic so_last = 1'b0;
  // a released line must not look like the last bit
  wire  so_wire = so_oe ? so_out : ~so_last;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    pause_n = 1'b1;
  end
  always @(posedge clk_sys) if (so_oe) so_last <= so_out;
  task automatic half();
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic sel(input logic m3);
    idle_hi = m3;
    sck = m3;
    half();
    cs_n = 1'b0;
    half();
  endtask
  task automatic desel();
    half();
    sck = idle_hi;
    half();
    cs_n = 1'b1;
    half();
  endtask
  task automatic xfer(input logic [7:0] tx, input int pz, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      si = tx[i];
      half();
      if (i == pz) begin
        pause_n = 1'b0;
        repeat (2) begin
          half();
          si = ~si;
          sck = 1'b1;
          half();
          sck = 1'b0;
        end
        si = tx[i];
        half();
        pause_n = 1'b1;
        half();
      end
      rx[i] = so_wire;
      sck = 1'b1;
      half();
    end
  endtask
endmodule // spi_host_model
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the serial flash pin front end
// assumes the host model moves pins on clk_sys falling edges
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       wp_n = 1'b1;
  logic       rx_ready = 1'b0;
  logic       core_busy = 1'b0;
  logic [7:0] r;
  logic [7:0] tx_b = 8'h5a;
  wire        tx_take;
  wire  [7:0] rx_byte, op_code;
  wire        cs_n, sck, si, pause_n, so_out, so_oe, rx_valid, rx_first;
  wire        op_start, op_end, op_abort, active, prot_locked, rx_overrun;
  int         err_count = 0, num_checks = 0, n_st = 0, n_end = 0, n_ab = 0;
  always #20 clk_sys = ~clk_sys;
  flash_pin_front flash_pin_front_i (.clk_sys(clk_sys), .rst(rst), .cs_n_pin(cs_n),
    .sck_pin(sck), .si_pin(si), .pause_n_pin(pause_n), .wp_n_pin(wp_n),
    .so_out(so_out), .so_oe(so_oe), .tx_byte(tx_b), .tx_take(tx_take), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_first(rx_first), .op_start(op_start),
    .op_code(op_code), .op_end(op_end), .op_abort(op_abort), .core_busy(core_busy),
    .active(active), .prot_locked(prot_locked), .rx_overrun(rx_overrun));
  spi_host_model host (.clk_sys(clk_sys), .so_out(so_out), .so_oe(so_oe),
    .cs_n(cs_n), .sck(sck), .si(si), .pause_n(pause_n));
  // the core model moves to the next read byte on every take pulse
  always @(posedge clk_sys) if (tx_take === 1'b1) tx_b <= tx_b + 8'h01;
  always @(posedge clk_sys) begin
    n_st += (op_start === 1'b1);
    n_end += (op_end === 1'b1);
    n_ab += (op_abort === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic pop(output logic [7:0] b);
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    b = rx_byte;
    rx_ready = 1'b1;
    @(negedge clk_sys);
    rx_ready = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic counts(input int s, input int e, input int a);
    chk("op_start count", s[7:0], n_st[7:0]);
    chk("op_end count", e[7:0], n_end[7:0]);
    chk("op_abort count", a[7:0], n_ab[7:0]);
    n_st = 0;
    n_end = 0;
    n_ab = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_read();
    host.sel(1'b0);
    host.xfer(8'h03, -1, r);
    for (int i = 0; i < 3; i++) begin
      host.xfer(8'h12 + i, -1, r);
      chk("rx first flag", (i == 0) ? 8'h01 : 8'h00, rx_first);
    end
    // three takes during the address bytes, so the first read byte is the fourth
    for (int k = 0; k < 2; k++) begin
      host.xfer(8'h00, -1, r);
      chk("read byte", 8'h5d + k, r);
    end
    chk("op_code", 8'h03, op_code);
    host.desel();
    chk("so_oe idle", 8'h00, so_oe);
    counts(1, 1, 0);
    pop(r);
    for (int i = 0; i < 5; i++) begin
      chk("rx addr", (i < 3) ? 8'h12 + i : 8'h00, r);
      if (i < 4) pop(r);
    end
  endtask
  task automatic t_ignored();
    repeat (2) host.xfer(8'hff, -1, r);
    chk("rx while deselected", 8'h00, rx_valid);
    host.sel(1'b1);
    host.xfer(8'hff, -1, r);
    host.xfer(8'h03, -1, r);
    host.desel();
    chk("rx after bad opcode", 8'h00, rx_valid);
    counts(0, 0, 1);
    host.sel(1'b1);
    host.xfer(8'h20, -1, r);
    host.xfer(8'haa, -1, r);
    host.desel();
    counts(0, 0, 1);
    pop(r);
  endtask
  task automatic t_pause_fill();
    host.sel(1'b0);
    host.xfer(8'h02, -1, r);
    // ten bytes fit (fifo, output stage, pending write); the eleventh is dropped
    for (int i = 0; i < 11; i++) host.xfer(8'ha1 + i, (i == 1) ? 3 : -1, r);
    chk("overrun", 8'h01, rx_overrun);
    core_busy = 1'b1;
    host.desel();
    repeat (8) @(negedge clk_sys);
    chk("active while busy", 8'h01, active);
    core_busy = 1'b0;
    counts(1, 1, 0);
    for (int i = 0; i < 10; i++) begin
      pop(r);
      chk("rx after pause", 8'ha1 + i, r);
    end
    chk("fifo empty", 8'h00, rx_valid);
    chk("standby", 8'h00, active);
  endtask
  task automatic t_protect();
    wp_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    chk("locked", 8'h01, prot_locked);
    wp_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    chk("unlocked", 8'h00, prot_locked);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #2_000_000;
    err_count++;
    summarize();
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    t_read();
    t_ignored();
    t_pause_fill();
    t_protect();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
